// ### rtl/bmd_regs.vh
/*
  register offsets, field positions, reset values and descriptor layout
  for the bus-master dma status block. assumes byte offsets on the
  channel's register port.
*/
`ifndef BMD_REGS_VH
`define BMD_REGS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define BMD_OFF_CMD 8'h00
`define BMD_OFF_STAT 8'h02
`define BMD_OFF_PTR 8'h04

// ------------------------------------------------------------
// command fields
// ------------------------------------------------------------
`define BMD_CMD_START 0
`define BMD_CMD_DIR 3

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define BMD_ST_SIMPLEX 7
`define BMD_ST_DRV1 6
`define BMD_ST_DRV0 5
`define BMD_ST_OVLCAP 4
`define BMD_ST_TAGMIS 3
`define BMD_ST_INT 2
`define BMD_ST_ERR 1
`define BMD_ST_ACT 0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define BMD_RST_CMD 8'h00
`define BMD_RST_STAT 8'h00
`define BMD_RST_PTR 32'h0000_0000

// ------------------------------------------------------------
// region descriptor layout
// ------------------------------------------------------------
`define BMD_DESC_STEP 32'h0000_0008
`define BMD_DESC_CNT_OFS 32'h0000_0004
`define BMD_EOT_BIT 31
`define BMD_CNT_W 16
`define BMD_WORD_BYTES 17'h0_0004
`define BMD_DMACK_GAP 3'h5

`endif

// ### rtl/bmd_fifo.v
/*
  synchronous fifo with valid/ready on both sides and a clear.
  assumes one clock; clear drops all contents.
*/
`timescale 1ns/1ps
module bmd_fifo #(
  parameter W = 32,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset_n,
  input wire clr,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ------------------------------------------------------------
  // storage and pointers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!reset_n || clr) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ### rtl/bmd_channel.v
/*
  one bus-master dma channel: command, status and table pointer
  registers, region descriptor walker, drive-side handshake and
  an 8-word data fifo with flush on drive interrupt.
  assumes a word-wide memory master port with one request in flight,
  and drive pins arriving asynchronously.
*/
// What this block does
// - status bit 7 reads the fixed single-channel-at-a-time flag
// - status bits 6 and 5 are software-kept drive dma capable marks
// - status bit 4 reads the fixed overlap-capable hardware flag
// - status bit 3 sets on overlap select with mismatching tag
// - interrupt flag sets on drive interrupt rise, cleared by writing one
// - error flag sets on failed memory transfer, cleared by writing one
// - active sets when start is written, clears when start is cleared
// - active clears after last transfer of an end-of-table region
// - active zero means drive data already sits in memory unless aborted
// - table pointer keeps bits 31:2, bits 1:0 reserved and zero
// - descriptors are 8 bytes: address then count, 8 bytes apart
// - data moves between memory and drive on drive dma requests
// - drive interrupt rise flushes buffered read data to memory
// - after that rise, status reads stall until buffered data has reached memory
// - start rising begins mastering; writing zero halts and drops state
// - command bit 3 picks direction: 0 memory reads, 1 memory writes
`timescale 1ns/1ps
`include "bmd_regs.vh"
module bmd_channel #(
  parameter SIMPLEX = 1'b0,
  parameter OVL_CAP = 1'b1,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_ack,
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  input wire mem_err,
  input wire drive_dmarq,
  output reg drive_dmack,
  input wire [31:0] drive_rdata,
  output reg [31:0] drive_wdata,
  input wire drive_intrq,
  input wire tag_mismatch,
  output reg active
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_FADDR = 4'b0010;
  localparam [3:0] S_FCNT = 4'b0100;
  localparam [3:0] S_XFER = 4'b1000;
  localparam [7:0] RST_CMD = `BMD_RST_CMD;
  localparam [31:0] RST_PTR = `BMD_RST_PTR;

  reg [3:0] state_r;
  reg start_r;
  reg dir_r;
  reg drv1_r;
  reg drv0_r;
  reg tagmis_r;
  reg int_r;
  reg err_r;
  reg [31:2] ptr_r;
  reg [31:2] desc_r;
  reg [31:2] buf_r;
  reg [16:0] rem_r;
  reg eot_r;
  reg flush_r;
  reg [2:0] irq_sync_r;
  reg irq_lvl_r;
  reg [2:0] rq_sync_r;
  reg rq_lvl_r;
  reg [2:0] gap_r;

  wire irq_rise;
  wire wr_cmd;
  wire wr_stat;
  wire wr_ptr;
  wire start_rise;
  wire start_fall;
  wire acked;
  wire fifo_clr;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [31:0] fifo_in_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [31:0] fifo_out_data;
  wire drv_take;
  wire drv_give;
  wire rd_stat;
  wire rd_ok;
  wire [7:0] stat_val;
  wire [7:0] cmd_val;
  wire [31:0] desc_next;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      irq_sync_r <= 3'h0;
      irq_lvl_r <= 1'b0;
      rq_sync_r <= 3'h0;
      rq_lvl_r <= 1'b0;
    end else begin
      irq_sync_r <= {irq_sync_r[1:0], drive_intrq};
      rq_sync_r <= {rq_sync_r[1:0], drive_dmarq};
      if (irq_sync_r[1] == irq_sync_r[2]) begin
        irq_lvl_r <= irq_sync_r[2];
      end
      if (rq_sync_r[1] == rq_sync_r[2]) begin
        rq_lvl_r <= rq_sync_r[2];
      end
    end
  end

  assign irq_rise = (irq_sync_r[1] == irq_sync_r[2]) && irq_sync_r[2] && !irq_lvl_r;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  assign wr_cmd = reg_wr && !reg_ack && (reg_addr == `BMD_OFF_CMD);
  assign wr_stat = reg_wr && !reg_ack && (reg_addr == `BMD_OFF_STAT);
  assign wr_ptr = reg_wr && !reg_ack && (reg_addr == `BMD_OFF_PTR);
  assign start_rise = wr_cmd && reg_wdata[`BMD_CMD_START] && !start_r;
  assign start_fall = wr_cmd && !reg_wdata[`BMD_CMD_START] && start_r;
  assign rd_stat = reg_rd && (reg_addr == `BMD_OFF_STAT);
  assign rd_ok = !rd_stat || !flush_r;
  assign acked = mem_req && mem_ack;

  assign stat_val = {SIMPLEX[0], drv1_r, drv0_r, OVL_CAP[0], tagmis_r, int_r, err_r, active};
  assign cmd_val = {4'h0, dir_r, 2'b00, start_r};
  assign desc_next = {desc_r, 2'b00} + `BMD_DESC_STEP;

  always @(posedge clk) begin
    if (!reset_n) begin
      reg_ack <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_ack <= 1'b0;
      if (!reg_ack && reg_wr) begin
        reg_ack <= 1'b1;
      end else if (!reg_ack && reg_rd && rd_ok) begin
        reg_ack <= 1'b1;
        case (reg_addr)
          `BMD_OFF_CMD: reg_rdata <= {24'h00_0000, cmd_val};
          `BMD_OFF_STAT: reg_rdata <= {24'h00_0000, stat_val};
          `BMD_OFF_PTR: reg_rdata <= {ptr_r, 2'b00};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // command, pointer and status flags
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      start_r <= RST_CMD[`BMD_CMD_START];
      dir_r <= 1'b0;
      ptr_r <= RST_PTR[31:2];
      drv1_r <= 1'b0;
      drv0_r <= 1'b0;
      tagmis_r <= 1'b0;
      int_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (wr_cmd) begin
        start_r <= reg_wdata[`BMD_CMD_START];
        if (!active) begin
          dir_r <= reg_wdata[`BMD_CMD_DIR];
        end
      end
      if (wr_ptr) begin
        ptr_r <= reg_wdata[31:2];
      end
      if (wr_stat) begin
        drv1_r <= reg_wdata[`BMD_ST_DRV1];
        drv0_r <= reg_wdata[`BMD_ST_DRV0];
      end
      tagmis_r <= tagmis_r && !(wr_stat && reg_wdata[`BMD_ST_TAGMIS]) || tag_mismatch;
      int_r <= int_r && !(wr_stat && reg_wdata[`BMD_ST_INT]) || irq_rise;
      err_r <= err_r && !(wr_stat && reg_wdata[`BMD_ST_ERR]) || (acked && mem_err);
    end
  end

  // ------------------------------------------------------------
  // flush tracking
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      flush_r <= 1'b0;
    end else if (irq_rise && dir_r && active) begin
      flush_r <= 1'b1;
    end else if ((!fifo_out_valid && !mem_req) || !active) begin
      flush_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // descriptor walker and memory master
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      active <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      desc_r <= 30'h0000_0000;
      buf_r <= 30'h0000_0000;
      rem_r <= 17'h0_0000;
      eot_r <= 1'b0;
    end else if (start_fall) begin
      state_r <= S_IDLE;
      active <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
    end else if (start_rise) begin
      state_r <= S_FADDR;
      active <= 1'b1;
      desc_r <= ptr_r;
      mem_req <= 1'b1;
      mem_we <= 1'b0;
      mem_addr <= {ptr_r, 2'b00};
    end else if (acked && mem_err) begin
      state_r <= S_IDLE;
      active <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE: begin
          mem_req <= 1'b0;
        end
        S_FADDR: begin
          if (acked) begin
            buf_r <= mem_rdata[31:2];
            mem_addr <= {desc_r, 2'b00} + `BMD_DESC_CNT_OFS;
            state_r <= S_FCNT;
          end
        end
        S_FCNT: begin
          if (acked) begin
            mem_req <= 1'b0;
            rem_r <= (mem_rdata[`BMD_CNT_W-1:0] == 16'h0000) ? 17'h1_0000 : {1'b0, mem_rdata[`BMD_CNT_W-1:0]};
            eot_r <= mem_rdata[`BMD_EOT_BIT];
            desc_r <= desc_next[31:2];
            state_r <= S_XFER;
          end
        end
        S_XFER: begin
          if (acked) begin
            mem_req <= 1'b0;
            buf_r <= buf_r + 30'h0000_0001;
            rem_r <= (rem_r < `BMD_WORD_BYTES) ? 17'h0_0000 : rem_r - `BMD_WORD_BYTES;
          end else if (!mem_req && rem_r == 17'h0_0000) begin
            if (eot_r) begin
              active <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              state_r <= S_FADDR;
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= {desc_r, 2'b00};
            end
          end else if (!mem_req && dir_r && fifo_out_valid) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= {buf_r, 2'b00};
            mem_wdata <= fifo_out_data;
          end else if (!mem_req && !dir_r && fifo_in_ready) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= {buf_r, 2'b00};
          end
        end
        default: begin
          state_r <= S_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // drive-side handshake
  // ------------------------------------------------------------
  // hold off until a dropped request has crossed the synchroniser
  assign drv_take = start_r && dir_r && rq_lvl_r && (gap_r == 3'h0) && fifo_in_ready;
  assign drv_give = start_r && !dir_r && rq_lvl_r && (gap_r == 3'h0) && fifo_out_valid;

  always @(posedge clk) begin
    if (!reset_n) begin
      drive_dmack <= 1'b0;
      drive_wdata <= 32'h0000_0000;
      gap_r <= 3'h0;
    end else begin
      drive_dmack <= drv_take || drv_give;
      if (drv_take || drv_give) begin
        gap_r <= `BMD_DMACK_GAP;
      end else if (gap_r != 3'h0) begin
        gap_r <= gap_r - 3'h1;
      end
      if (drv_give) begin
        drive_wdata <= fifo_out_data;
      end
    end
  end

  // ------------------------------------------------------------
  // data fifo
  // ------------------------------------------------------------
  assign fifo_clr = start_fall || start_rise;
  assign fifo_in_valid = dir_r ? drv_take : (state_r == S_XFER && acked && !mem_err);
  assign fifo_in_data = dir_r ? drive_rdata : mem_rdata;
  assign fifo_out_ready = dir_r ? (state_r == S_XFER && acked && mem_we && !mem_err) : drv_give;

  bmd_fifo #(
    .W(32),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .clr(fifo_clr),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
endmodule

// ### tb/bmd_chk.sv
/*
  port assertions for bmd_channel.
  assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module bmd_chk #(
  parameter SIMPLEX = 1'b0,
  parameter OVL_CAP = 1'b1
) (
  input wire clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire reg_ack,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire mem_ack,
  input wire mem_err,
  input wire drive_dmack,
  input wire active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // register side
  // ------------------------------------------------------------
  a_simplex_fixed: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) == 8'h02 |-> reg_rdata[7] == SIMPLEX)
    else $error("status bit 7 wrong");
  a_ovl_fixed: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) == 8'h02 |-> reg_rdata[4] == OVL_CAP)
    else $error("status bit 4 wrong");
  a_ptr_low_zero: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) == 8'h04 |-> reg_rdata[1:0] == 2'b00)
    else $error("pointer low bits not zero");
  a_act_cause: assert property ($rose(active) |-> $past(reg_wr) && $past(reg_addr) == 8'h00 && $past(reg_wdata[0]))
    else $error("active rose without start");
  a_stop_drops: assert property (reg_ack && $past(reg_wr) && $past(reg_addr) == 8'h00 && !$past(reg_wdata[0]) |-> !active)
    else $error("active stayed after stop");
  a_ack_pulse: assert property (reg_ack |=> !reg_ack)
    else $error("reg_ack longer than one cycle");
  // ------------------------------------------------------------
  // memory and drive side
  // ------------------------------------------------------------
  a_err_halts: assert property (mem_req && mem_ack && mem_err |=> !active)
    else $error("active stayed after memory error");
  a_req_hold: assert property (mem_req && !mem_ack && !(reg_wr && !reg_ack && reg_addr == 8'h00 && !reg_wdata[0])
    |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  a_word_align: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("memory address not word aligned");
  a_dmack_gap: assert property (drive_dmack |=> !drive_dmack [*5])
    else $error("drive_dmack back to back");
endmodule

bind bmd_channel bmd_chk #(.SIMPLEX(SIMPLEX), .OVL_CAP(OVL_CAP)) chk_u (.clk(clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_ack(reg_ack), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .mem_err(mem_err), .drive_dmack(drive_dmack), .active(active));

// ### tb/bmd_ide_model.sv
/*
  far side model: word memory on the master port and a drive that
  raises dma requests and its interrupt pin.
  assumes the bench preloads mem and steers lat, err_on, n_words, intr.
*/
`timescale 1ns/1ps
module bmd_ide_model (
  input wire clk,
  input wire reset_n,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic mem_err,
  input wire [1:0] lat,
  input wire err_on,
  input wire [3:0] n_words,
  input wire intr,
  output wire drive_dmarq,
  input wire drive_dmack,
  output wire [31:0] drive_rdata,
  input wire [31:0] drive_wdata,
  output wire drive_intrq
);
  logic [31:0] mem [0:255];
  logic [31:0] got [0:15];
  logic [1:0] wt;
  logic [3:0] sent;
  wire [31:0] word_now = 32'hd00d_0000 + {28'h000_0000, sent};
  // request held until the promised words moved
  assign drive_dmarq = reset_n && sent < n_words;
  assign drive_rdata = drive_dmarq ? word_now : ~word_now;
  assign drive_intrq = intr;
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_err <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!reset_n) begin
      wt <= 2'd0;
      sent <= 4'd0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      if (mem_req && !mem_ack) begin
        wt <= wt + 2'd1;
        if (wt == lat) begin
          wt <= 2'd0;
          mem_ack <= 1'b1;
          mem_err <= err_on;
          mem_rdata <= mem[mem_addr[9:2]];
          if (mem_we && !err_on) begin
            mem[mem_addr[9:2]] <= mem_wdata;
          end
        end
      end
      if (drive_dmack) begin
        got[sent] <= drive_wdata;
        sent <= sent + 4'd1;
      end
    end
  end
endmodule

// ### tb/tb.sv
/*
  self-checking bench for bmd_channel with the drive and memory model.
  assumes default parameters: status idle value 8'h10.
*/
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic tag_mismatch = 1'b0;
  logic [1:0] lat = 2'd1;
  logic err_on = 1'b0;
  logic [3:0] n_words = 4'd0;
  logic intr = 1'b0;
  wire [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, drive_rdata, drive_wdata;
  wire reg_ack, mem_req, mem_we, mem_ack, mem_err, drive_dmarq, drive_dmack, drive_intrq, active;
  int bad_count = 0;
  int n_checks = 0;
  localparam logic [31:0] IDLE = 32'h0000_0010;
  always #5 clk = ~clk;
  bmd_channel dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
    .drive_dmarq(drive_dmarq), .drive_dmack(drive_dmack), .drive_rdata(drive_rdata), .drive_wdata(drive_wdata),
    .drive_intrq(drive_intrq), .tag_mismatch(tag_mismatch), .active(active));
  bmd_ide_model ide_u (.clk(clk), .reset_n(reset_n), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err), .lat(lat),
    .err_on(err_on), .n_words(n_words), .intr(intr), .drive_dmarq(drive_dmarq), .drive_dmack(drive_dmack),
    .drive_rdata(drive_rdata), .drive_wdata(drive_wdata), .drive_intrq(drive_intrq));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i = 0;
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    do begin
      @(posedge clk);
      i++;
    end while (reg_ack !== 1'b1 && i < 400);
    if (i >= 400) chk("reg_ack", 32'h0000_0000, 32'h0000_0001);
    q = reg_rdata;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(n, q, e);
  endtask
  task automatic wait_sent(input logic [3:0] n);
    for (int i = 0; i < 400 && ide_u.sent !== n; i++) @(posedge clk);
    chk("words sent", ide_u.sent, n);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rd_chk(8'h02, IDLE, "status reset");
    rd_chk(8'h04, 32'h0000_0000, "pointer reset");
    rd_chk(8'h08, 32'h0000_0000, "unmapped");
    wr(8'h04, 32'hffff_ffff);
    rd_chk(8'h04, 32'hffff_fffc, "pointer");
    wr(8'h02, 32'h0000_00ff);
    rd_chk(8'h02, 32'h0000_0070, "drive marks");
    wr(8'h02, 32'h0000_0000);
    rd_chk(8'h02, IDLE, "marks cleared");
    @(posedge clk);
    tag_mismatch <= 1'b1;
    @(posedge clk);
    tag_mismatch <= 1'b0;
    rd_chk(8'h02, 32'h0000_0018, "tag flag");
    wr(8'h02, 32'h0000_0008);
    rd_chk(8'h02, IDLE, "tag cleared");
    $display("test regs done");
  endtask
  task automatic t_flush;
    ide_u.mem[64] = 32'h0000_0200;
    ide_u.mem[65] = 32'h0000_0004;
    ide_u.mem[66] = 32'h0000_0240;
    ide_u.mem[67] = 32'h8000_0010;
    lat <= 2'd2;
    wr(8'h04, 32'h0000_0100);
    wr(8'h00, 32'h0000_0008);
    wr(8'h02, 32'h0000_0006);
    n_words <= 4'd2;
    wr(8'h00, 32'h0000_0009);
    wait_sent(4'd2);
    intr <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'h02, 32'h0000_0015, "status after intr");
    chk("region 0 word", ide_u.mem[128], 32'hd00d_0000);
    chk("region 1 word", ide_u.mem[144], 32'hd00d_0001);
    wr(8'h00, 32'h0000_0008);
    rd_chk(8'h02, 32'h0000_0014, "status after stop");
    wr(8'h02, 32'h0000_0004);
    rd_chk(8'h02, IDLE, "intr cleared");
    intr <= 1'b0;
    $display("test flush done");
  endtask
  task automatic t_eot;
    logic [3:0] base;
    base = ide_u.sent;
    ide_u.mem[96] = 32'h0000_0300;
    ide_u.mem[97] = 32'h8000_0008;
    ide_u.mem[192] = 32'h1111_0000;
    ide_u.mem[193] = 32'h2222_0001;
    lat <= 2'd0;
    wr(8'h04, 32'h0000_0180);
    n_words <= base + 4'd2;
    wr(8'h00, 32'h0000_0001);
    wait_sent(base + 4'd2);
    for (int i = 0; i < 400 && active !== 1'b0; i++) @(posedge clk);
    chk("active at end", {31'h0000_0000, active}, 32'h0000_0000);
    chk("drive word 0", ide_u.got[base], 32'h1111_0000);
    chk("drive word 1", ide_u.got[base + 4'd1], 32'h2222_0001);
    wr(8'h00, 32'h0000_0000);
    err_on <= 1'b1;
    wr(8'h00, 32'h0000_0001);
    for (int i = 0; i < 400 && active !== 1'b0; i++) @(posedge clk);
    rd_chk(8'h02, 32'h0000_0012, "error flag");
    err_on <= 1'b0;
    wr(8'h02, 32'h0000_0002);
    rd_chk(8'h02, IDLE, "error cleared");
    $display("test eot_error done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_regs;
    t_flush;
    t_eot;
    stop_test;
  end
  initial begin
    #200000;
    bad_count++;
    stop_test;
  end
endmodule
